// File: inc/spisd_pkg.sv
package spisd_pkg;

   // Register map (byte addresses on the 8-bit register port)
   localparam logic [7:0] SPISD_STATUS_ADDR = 8'hC4;
   localparam logic [7:0] SPISD_DATA_ADDR   = 8'hC5;
   localparam logic [7:0] SPISD_CTRL_ADDR   = 8'hD4;

   // Status/control register field positions
   localparam int SPISD_ST_DONE_BIT  = 7;
   localparam int SPISD_ST_RSVD_BIT  = 6;
   localparam int SPISD_ST_OVR_BIT   = 5;
   localparam int SPISD_ST_FAULT_BIT = 4;
   localparam int SPISD_ST_TXE_BIT   = 3;
   localparam int SPISD_ST_LSB_BIT   = 2;
   localparam int SPISD_ST_TEIE_BIT  = 1;
   localparam int SPISD_ST_FIE_BIT   = 0;

   typedef struct packed {
      logic rate_select_high;
      logic interface_enable_bit;
      logic select_pin_disable;
      logic master_role_bit;
      logic clk_polarity;
      logic clk_phase;
      logic rate_select_mid;
      logic rate_select_low;
   } spisd_ctrl_t;

   typedef struct packed {
      logic transfer_done_flag;
      logic overrun_flag;
      logic mode_fault_flag;
      logic tx_empty_flag;
   } spisd_flags_t;

   typedef enum logic {
      SPISD_IDLE = 1'b0,
      SPISD_RUN  = 1'b1
   } spisd_state_t;

   localparam logic [7:0]   SPISD_CTRL_RESET  = 8'h14;
   localparam spisd_flags_t SPISD_FLAGS_RESET = 4'h1;
   localparam logic [3:0]   SPISD_BITS_PER_BYTE = 4'h8;

   // Half periods of the master clock, in system clocks
   localparam logic [6:0] SPISD_HALF_DIV4   = 7'h02;
   localparam logic [6:0] SPISD_HALF_DIV8   = 7'h04;
   localparam logic [6:0] SPISD_HALF_DIV16  = 7'h08;
   localparam logic [6:0] SPISD_HALF_DIV32  = 7'h10;
   localparam logic [6:0] SPISD_HALF_DIV64  = 7'h20;
   localparam logic [6:0] SPISD_HALF_DIV128 = 7'h40;

   // Invalid codes fall back to the slowest rate so a bad setting stays harmless
   function automatic logic [6:0] spisd_half_period(input logic [2:0] rate);
      case (rate)
         3'h1:    spisd_half_period = SPISD_HALF_DIV4;
         3'h2:    spisd_half_period = SPISD_HALF_DIV8;
         3'h3:    spisd_half_period = SPISD_HALF_DIV16;
         3'h4:    spisd_half_period = SPISD_HALF_DIV32;
         3'h5:    spisd_half_period = SPISD_HALF_DIV64;
         3'h6:    spisd_half_period = SPISD_HALF_DIV128;
         default: spisd_half_period = SPISD_HALF_DIV128;
      endcase
   endfunction

endpackage

// File: src/spisd_sync.sv
`timescale 1ns/1ps
module spisd_sync
   import spisd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk_in,
   input  wire logic             reset_in,
   input  wire logic             clk_en_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stable_reg;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         meta_reg   <= '0;
         stable_reg <= '0;
      end else if (clk_en_in) begin
         meta_reg   <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;

endmodule

// File: src/spisd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Done flag sets when a byte completes; cleared while a master exchange runs.
// - Done flag clears on status read followed by data read or write.
// - Overrun sets when a byte completes with done still set; old byte kept.
// - Status read clears overrun and mode fault.
// - Mode fault sets on a select level wrong for the role.
// - Slave fault: data ignored while select high; restart when select low.
// - Master fault clears the interface enable bit.
// - Transmit-empty set when shift register free, cleared once loaded.
// - Status bit 2 selects LSB first; clear means MSB first.
// - Bit 1 routes transfer request to transmit-empty instead of done.
// - Fault request only while fault enable bit 0 is set.
// - Reset clears status bits 7, 5 and 4.
// - Data write loads the shift register directly.
// - Data read returns the receive buffer, never the shift register.
// - Clearing enable mid-exchange stops the engine at once.
// - Data write during an exchange counts as overrun.
// - Done flag requests the transfer interrupt only without transmit-empty enable.
// - Select disable suppresses mode fault requests.
// - Slave with select in use and high: data output released, bit counter cleared.
module spisd_top
   import spisd_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   input  wire logic       clk_en_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe_n_out,
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe_n_out,
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe_n_out,
   input  wire logic       ss_n_in,
   output logic            irq_xfer_out,
   output logic            irq_fault_out
);

   logic [3:0]   pin_sync;
   logic         sck_s;
   logic         mosi_s;
   logic         miso_s;
   logic         ss_n_s;

   spisd_state_t state_reg, state_next;
   spisd_ctrl_t  ctrl_reg, ctrl_next;
   spisd_flags_t flags_reg, flags_next;
   logic         lsb_first_select_reg, lsb_first_select_next;
   logic         tx_empty_irq_enable_reg, tx_empty_irq_enable_next;
   logic         fault_irq_enable_reg, fault_irq_enable_next;
   logic [7:0]   rx_buf_reg, rx_buf_next;
   logic [7:0]   tx_sh_reg, tx_sh_next;
   logic [7:0]   rx_sh_reg, rx_sh_next;
   logic [3:0]   bit_cnt_reg, bit_cnt_next;
   logic [6:0]   div_cnt_reg, div_cnt_next;
   logic         sck_reg, sck_next;
   logic         sck_prev_reg, sck_prev_next;
   logic         armed_reg, armed_next;
   logic [7:0]   rdata_reg, rdata_next;
   logic         dout_reg, dout_next;
   logic         sck_oe_n_reg, sck_oe_n_next;
   logic         mosi_oe_n_reg, mosi_oe_n_next;
   logic         miso_oe_n_reg, miso_oe_n_next;
   logic         irq_xfer_reg, irq_xfer_next;
   logic         irq_fault_reg, irq_fault_next;

   logic         select_used;
   logic         selected;
   logic         busy;
   logic         lead_ev;
   logic         trail_ev;
   logic         sample_ev;
   logic         shift_ev;
   logic         din;
   logic [3:0]   cnt_after;
   logic         wr_status;
   logic         wr_data;
   logic         wr_ctrl;
   logic         rd_status;
   logic         rd_data;

   spisd_sync #(
      .WIDTH (4)
   ) u_pin_sync (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .clk_en_in  (clk_en_in),
      .async_in   ({sck_in, mosi_in, miso_in, ss_n_in}),
      .sync_out   (pin_sync)
   );

   assign sck_s  = pin_sync[3];
   assign mosi_s = pin_sync[2];
   assign miso_s = pin_sync[1];
   assign ss_n_s = pin_sync[0];

   always_comb begin
      state_next               = state_reg;
      ctrl_next                = ctrl_reg;
      flags_next               = flags_reg;
      lsb_first_select_next    = lsb_first_select_reg;
      tx_empty_irq_enable_next = tx_empty_irq_enable_reg;
      fault_irq_enable_next    = fault_irq_enable_reg;
      rx_buf_next              = rx_buf_reg;
      tx_sh_next               = tx_sh_reg;
      rx_sh_next               = rx_sh_reg;
      bit_cnt_next             = bit_cnt_reg;
      div_cnt_next             = div_cnt_reg;
      sck_next                 = (state_reg == SPISD_RUN) ? sck_reg : ctrl_reg.clk_polarity;
      sck_prev_next            = sck_s;
      armed_next               = armed_reg;
      rdata_next               = 8'h00;
      lead_ev                  = 1'b0;
      trail_ev                 = 1'b0;
      cnt_after                = bit_cnt_reg;

      wr_status = reg_wr_in && (reg_addr_in == SPISD_STATUS_ADDR);
      wr_data   = reg_wr_in && (reg_addr_in == SPISD_DATA_ADDR);
      wr_ctrl   = reg_wr_in && (reg_addr_in == SPISD_CTRL_ADDR);
      rd_status = reg_rd_in && (reg_addr_in == SPISD_STATUS_ADDR);
      rd_data   = reg_rd_in && (reg_addr_in == SPISD_DATA_ADDR);

      // In slave mode with phase 0 the select pin stays in use even when disabled
      select_used = !ctrl_reg.select_pin_disable
                    || (!ctrl_reg.master_role_bit && !ctrl_reg.clk_phase);
      selected    = select_used ? !ss_n_s : 1'b1;
      busy        = (state_reg == SPISD_RUN)
                    && (ctrl_reg.master_role_bit || (bit_cnt_reg != 4'h0));
      din         = ctrl_reg.master_role_bit ? miso_s : mosi_s;

      if (reg_rd_in) begin
         case (reg_addr_in)
            SPISD_STATUS_ADDR: begin
               rdata_next[SPISD_ST_DONE_BIT]  = flags_reg.transfer_done_flag;
               rdata_next[SPISD_ST_RSVD_BIT]  = 1'b0;
               rdata_next[SPISD_ST_OVR_BIT]   = flags_reg.overrun_flag;
               rdata_next[SPISD_ST_FAULT_BIT] = flags_reg.mode_fault_flag;
               rdata_next[SPISD_ST_TXE_BIT]   = flags_reg.tx_empty_flag;
               rdata_next[SPISD_ST_LSB_BIT]   = lsb_first_select_reg;
               rdata_next[SPISD_ST_TEIE_BIT]  = tx_empty_irq_enable_reg;
               rdata_next[SPISD_ST_FIE_BIT]   = fault_irq_enable_reg;
            end
            SPISD_DATA_ADDR: rdata_next = rx_buf_reg;
            SPISD_CTRL_ADDR: rdata_next = ctrl_reg;
            default:         rdata_next = 8'h00;
         endcase
      end

      // Software side effects come first so hardware sets below win
      if (wr_ctrl) begin
         ctrl_next = reg_wdata_in;
      end
      if (wr_status) begin
         lsb_first_select_next    = reg_wdata_in[SPISD_ST_LSB_BIT];
         tx_empty_irq_enable_next = reg_wdata_in[SPISD_ST_TEIE_BIT];
         fault_irq_enable_next    = reg_wdata_in[SPISD_ST_FIE_BIT];
      end
      if (rd_status) begin
         flags_next.overrun_flag    = 1'b0;
         flags_next.mode_fault_flag = 1'b0;
         armed_next                 = flags_reg.transfer_done_flag;
      end
      if ((rd_data || wr_data) && !rd_status) begin
         if (armed_reg) begin
            flags_next.transfer_done_flag = 1'b0;
         end
         armed_next = 1'b0;
      end
      if (wr_data) begin
         if (busy) begin
            flags_next.overrun_flag = 1'b1;
         end else begin
            tx_sh_next               = reg_wdata_in;
            flags_next.tx_empty_flag = 1'b0;
            if (ctrl_reg.interface_enable_bit && ctrl_reg.master_role_bit) begin
               state_next                    = SPISD_RUN;
               bit_cnt_next                  = 4'h0;
               div_cnt_next                  = 7'h00;
               sck_next                      = ctrl_reg.clk_polarity;
               flags_next.transfer_done_flag = 1'b0;
            end
         end
      end

      // Clock edges: the master makes its own, the slave watches the pin
      if (state_reg == SPISD_RUN) begin
         if (ctrl_reg.master_role_bit) begin
            div_cnt_next = div_cnt_reg + 7'h01;
            if (div_cnt_next == spisd_half_period({ctrl_reg.rate_select_high,
                                                   ctrl_reg.rate_select_mid,
                                                   ctrl_reg.rate_select_low})) begin
               div_cnt_next = 7'h00;
               sck_next     = !sck_reg;
               lead_ev      = (sck_reg == ctrl_reg.clk_polarity);
               trail_ev     = (sck_reg != ctrl_reg.clk_polarity);
            end
         end else if (sck_s != sck_prev_reg) begin
            lead_ev  = (sck_prev_reg == ctrl_reg.clk_polarity);
            trail_ev = (sck_prev_reg != ctrl_reg.clk_polarity);
         end
      end
      sample_ev = ctrl_reg.clk_phase ? trail_ev : lead_ev;
      shift_ev  = ctrl_reg.clk_phase ? lead_ev : trail_ev;

      if (sample_ev) begin
         rx_sh_next = lsb_first_select_reg ? {din, rx_sh_reg[7:1]}
                                           : {rx_sh_reg[6:0], din};
         cnt_after  = bit_cnt_reg + 4'h1;
      end
      bit_cnt_next = (state_reg == SPISD_RUN) ? cnt_after : bit_cnt_next;
      if (shift_ev && (bit_cnt_reg != 4'h0)) begin
         tx_sh_next = lsb_first_select_reg ? {1'b0, tx_sh_reg[7:1]}
                                           : {tx_sh_reg[6:0], 1'b0};
      end
      if (trail_ev && (cnt_after == SPISD_BITS_PER_BYTE)) begin
         bit_cnt_next             = 4'h0;
         flags_next.tx_empty_flag = 1'b1;
         if (flags_next.transfer_done_flag) begin
            flags_next.overrun_flag = 1'b1;
         end else begin
            rx_buf_next                   = rx_sh_next;
            flags_next.transfer_done_flag = 1'b1;
         end
         if (ctrl_reg.master_role_bit) begin
            state_next = SPISD_IDLE;
            sck_next   = ctrl_reg.clk_polarity;
         end
      end

      // Select pin supervision and role handling
      if (!ctrl_reg.interface_enable_bit) begin
         state_next               = SPISD_IDLE;
         bit_cnt_next             = 4'h0;
         sck_next                 = ctrl_reg.clk_polarity;
         flags_next.tx_empty_flag = 1'b1;
      end else if (ctrl_reg.master_role_bit) begin
         if (select_used && !ss_n_s) begin
            flags_next.mode_fault_flag     = 1'b1;
            ctrl_next.interface_enable_bit = 1'b0;
            state_next                     = SPISD_IDLE;
            bit_cnt_next                   = 4'h0;
            sck_next                       = ctrl_reg.clk_polarity;
         end
      end else if (!selected) begin
         if (state_reg == SPISD_RUN) begin
            flags_next.mode_fault_flag = 1'b1;
         end
         state_next   = SPISD_IDLE;
         bit_cnt_next = 4'h0;
      end else if (state_reg == SPISD_IDLE) begin
         state_next   = SPISD_RUN;
         bit_cnt_next = 4'h0;
      end

      sck_oe_n_next  = !(ctrl_reg.interface_enable_bit && ctrl_reg.master_role_bit);
      mosi_oe_n_next = sck_oe_n_next;
      miso_oe_n_next = !(ctrl_reg.interface_enable_bit && !ctrl_reg.master_role_bit
                         && selected && (state_next == SPISD_RUN));
      // Output bit follows the next shift value so the pin lags by no extra cycle
      dout_next = lsb_first_select_next ? tx_sh_next[0] : tx_sh_next[7];

      irq_xfer_next  = tx_empty_irq_enable_next ? flags_next.tx_empty_flag
                                                : flags_next.transfer_done_flag;
      irq_fault_next = fault_irq_enable_next && flags_next.mode_fault_flag
                       && !ctrl_next.select_pin_disable;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_reg               <= SPISD_IDLE;
         ctrl_reg                <= SPISD_CTRL_RESET;
         flags_reg               <= SPISD_FLAGS_RESET;
         lsb_first_select_reg    <= 1'b0;
         tx_empty_irq_enable_reg <= 1'b0;
         fault_irq_enable_reg    <= 1'b0;
         rx_buf_reg              <= 8'h00;
         tx_sh_reg               <= 8'h00;
         rx_sh_reg               <= 8'h00;
         bit_cnt_reg             <= 4'h0;
         div_cnt_reg             <= 7'h00;
         sck_reg                 <= 1'b0;
         sck_prev_reg            <= 1'b0;
         armed_reg               <= 1'b0;
         rdata_reg               <= 8'h00;
         dout_reg                <= 1'b0;
         sck_oe_n_reg            <= 1'b1;
         mosi_oe_n_reg           <= 1'b1;
         miso_oe_n_reg           <= 1'b1;
         irq_xfer_reg            <= 1'b0;
         irq_fault_reg           <= 1'b0;
      end else if (clk_en_in) begin
         state_reg               <= state_next;
         ctrl_reg                <= ctrl_next;
         flags_reg               <= flags_next;
         lsb_first_select_reg    <= lsb_first_select_next;
         tx_empty_irq_enable_reg <= tx_empty_irq_enable_next;
         fault_irq_enable_reg    <= fault_irq_enable_next;
         rx_buf_reg              <= rx_buf_next;
         tx_sh_reg               <= tx_sh_next;
         rx_sh_reg               <= rx_sh_next;
         bit_cnt_reg             <= bit_cnt_next;
         div_cnt_reg             <= div_cnt_next;
         sck_reg                 <= sck_next;
         sck_prev_reg            <= sck_prev_next;
         armed_reg               <= armed_next;
         rdata_reg               <= rdata_next;
         dout_reg                <= dout_next;
         sck_oe_n_reg            <= sck_oe_n_next;
         mosi_oe_n_reg           <= mosi_oe_n_next;
         miso_oe_n_reg           <= miso_oe_n_next;
         irq_xfer_reg            <= irq_xfer_next;
         irq_fault_reg           <= irq_fault_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign sck_out       = sck_reg;
   assign sck_oe_n_out  = sck_oe_n_reg;
   assign mosi_out      = dout_reg;
   assign mosi_oe_n_out = mosi_oe_n_reg;
   assign miso_out      = dout_reg;
   assign miso_oe_n_out = miso_oe_n_reg;
   assign irq_xfer_out  = irq_xfer_reg;
   assign irq_fault_out = irq_fault_reg;

endmodule

// File: dv/spisd_chk.sv
`timescale 1ns/1ps
module spisd_chk
   import spisd_pkg::*;
(
   input wire logic       sys_clk_in,
   input wire logic       reset_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       sck_oe_n_out,
   input wire logic       mosi_oe_n_out,
   input wire logic       miso_oe_n_out,
   input wire logic       ss_n_in,
   input wire logic       irq_xfer_out,
   input wire logic       irq_fault_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   logic rd_st;
   logic rd_da;
   logic wr_off;
   assign rd_st  = reg_rd_in && (reg_addr_in == SPISD_STATUS_ADDR);
   assign rd_da  = reg_rd_in && (reg_addr_in == SPISD_DATA_ADDR);
   assign wr_off = reg_wr_in && (reg_addr_in == SPISD_CTRL_ADDR) && !reg_wdata_in[6];

   chk_reset_quiet: assert property ($past(reset_in) |->
      reg_rdata_out == 8'h00 && !irq_xfer_out && !irq_fault_out && sck_oe_n_out)
      else $error("outputs not idle after reset");
   chk_rsvd_zero: assert property ($past(rd_st) |-> !reg_rdata_out[6])
      else $error("reserved status bit reads one");
   chk_flags_clear: assert property ($past(rd_st, 2) && $past(rd_st) |->
      reg_rdata_out[5:4] == 2'b00)
      else $error("error flags survive a status read");
   chk_xfer_route: assert property ($past(rd_st) |->
      irq_xfer_out == (reg_rdata_out[1] ? reg_rdata_out[3] : reg_rdata_out[7]))
      else $error("transfer request follows the wrong flag");
   // Status read then data read with done shown must drop the done request
   chk_done_clear: assert property (rd_st ##1 (rd_da && reg_rdata_out[7] &&
      !reg_rdata_out[1]) |-> ##[1:2] !irq_xfer_out)
      else $error("done not cleared by the clear sequence");
   chk_miso_release: assert property (ss_n_in [*4] |=> miso_oe_n_out)
      else $error("data output driven while deselected");
   chk_disable_stop: assert property ($past(wr_off) |->
      ##[0:2] sck_oe_n_out && mosi_oe_n_out)
      else $error("pins still driven after disable");
   chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside its cycle");
endmodule

bind spisd_top spisd_chk u_chk (
   .sys_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
   .reg_rdata_out, .sck_oe_n_out, .mosi_oe_n_out, .miso_oe_n_out, .ss_n_in,
   .irq_xfer_out, .irq_fault_out
);

// File: dv/spisd_peer.sv
`timescale 1ns/1ps
module spisd_peer (
   input  wire logic       sck_in,
   input  wire logic       sel_n_in,
   input  wire logic       mosi_in,
   input  wire logic       lsb_in,
   input  wire logic [7:0] tx_in,
   output logic            miso_out,
   output logic      [7:0] rx_out
);
   logic [7:0] sh_reg;
   logic       hold_reg;
   logic       first_reg;
   logic       cur;
   assign cur = lsb_in ? sh_reg[0] : sh_reg[7];
   // Released line shows the opposite of its last bit, so a stale sample cannot match
   assign miso_out = sel_n_in ? hold_reg : cur;
   always @(posedge sel_n_in) hold_reg <= ~cur;
   always @(negedge sel_n_in) begin
      sh_reg    <= tx_in;
      first_reg <= 1'b1;
   end
   // An idle-high clock leads with a falling edge that must not shift the first bit away
   always @(negedge sck_in) if (!sel_n_in && !first_reg) sh_reg <= lsb_in ? sh_reg >> 1 : sh_reg << 1;
   always @(posedge sck_in) begin
      first_reg <= 1'b0;
      if (!sel_n_in) rx_out <= lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
   end
endmodule

// File: dv/spisd_top_tb.sv
`timescale 1ns/1ps
module spisd_top_tb;
   import spisd_pkg::*;
   localparam logic [7:0] ST = SPISD_STATUS_ADDR;
   localparam logic [7:0] DA = SPISD_DATA_ADDR;
   localparam logic [7:0] CT = SPISD_CTRL_ADDR;
   logic       sys_clk_in, reset_in, clk_en_in, reg_wr_in, reg_rd_in, ss_n_in;
   logic       sck_out, sck_oe_n_out, mosi_out, mosi_oe_n_out, miso_out, miso_oe_n_out;
   logic       irq_xfer_out, irq_fault_out, tb_sck, tb_mosi, peer_sel_n, peer_lsb, peer_miso;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, peer_tx, peer_rx;
   logic [7:0] f_ctl [3] = '{8'h52, 8'h52, 8'h72};
   logic [7:0] f_ie  [3] = '{8'h01, 8'h00, 8'h01};
   logic [7:0] f_irq [3] = '{8'h01, 8'h00, 8'h00};
   logic [7:0] f_ce  [3] = '{8'h12, 8'h12, 8'h72};
   logic [7:0] f_st  [3] = '{8'h19, 8'h18, 8'h09};
   wire        sck_in, mosi_in, miso_in;
   int         err_total, checks_done;
   // Enabled driver wins; otherwise the bench's clock, the bench's data bit or the peer
   assign sck_in  = !sck_oe_n_out  ? sck_out  : tb_sck;
   assign mosi_in = !mosi_oe_n_out ? mosi_out : tb_mosi;
   assign miso_in = !miso_oe_n_out ? miso_out : peer_miso;

   spisd_top u_dut (
      .sys_clk_in, .reset_in, .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .sck_in, .sck_out, .sck_oe_n_out, .mosi_in, .mosi_out,
      .mosi_oe_n_out, .miso_in, .miso_out, .miso_oe_n_out, .ss_n_in, .irq_xfer_out,
      .irq_fault_out
   );
   spisd_peer u_peer (
      .sck_in(sck_in), .sel_n_in(peer_sel_n), .mosi_in(mosi_in), .lsb_in(peer_lsb),
      .tx_in(peer_tx), .miso_out(peer_miso), .rx_out(peer_rx)
   );

   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   task automatic tally_and_finish;
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   // Strobes drop on the edge that takes them, so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk(reg_rdata_out, exp);
   endtask
   task automatic wait_irq(input logic v);
      int i;
      i = 0;
      while (irq_xfer_out !== v && i < 400) begin
         cyc(1);
         i++;
      end
      chk({7'h00, irq_xfer_out}, {7'h00, v});
   endtask
   task automatic xm(input logic [7:0] d, input logic [7:0] p);
      peer_sel_n <= 1'b1;
      peer_tx    <= p;
      cyc(2);
      peer_sel_n <= 1'b0;
      cyc(2);
      wr(DA, d);
   endtask
   // Four system clocks a half period: 160 ns link period
   task automatic pulses(input int n, input logic m);
      tb_mosi <= m;
      repeat (n) begin
         cyc(4);
         tb_sck <= 1'b1;
         cyc(4);
         tb_sck <= 1'b0;
      end
   endtask

   initial begin
      #300000;
      err_total++;
      tally_and_finish;
   end

   initial begin
      reset_in = 1'b1;
      clk_en_in = 1'b1;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      ss_n_in = 1'b1;
      tb_sck = 1'b0;
      tb_mosi = 1'b1;
      peer_sel_n = 1'b1;
      peer_lsb = 1'b0;
      peer_tx = 8'h00;
      err_total = 0;
      checks_done = 0;
      cyc(16);
      reset_in <= 1'b0;
      rdc(ST, 8'h08);
      rdc(CT, 8'h14);
      rdc(8'h00, 8'h00);
      $display("test reset finished");
      wr(CT, 8'h52);
      xm(8'h3C, 8'hA5);
      rdc(ST, 8'h00);
      wait_irq(1'b1);
      rdc(ST, 8'h88);
      rdc(DA, 8'hA5);
      rdc(ST, 8'h08);
      chk(peer_rx, 8'h3C);
      wr(ST, 8'h02);
      xm(8'h11, 8'hC3);
      wait_irq(1'b0);
      wait_irq(1'b1);
      wr(ST, 8'h00);
      cyc(2);
      chk({7'h00, irq_xfer_out}, 8'h01);
      rdc(ST, 8'h88);
      rdc(DA, 8'hC3);
      rdc(ST, 8'h08);
      $display("test master finished");
      xm(8'h66, 8'h5A);
      wr(DA, 8'h99);
      wait_irq(1'b1);
      rdc(ST, 8'hA8);
      rdc(DA, 8'h5A);
      chk(peer_rx, 8'h66);
      wr(ST, 8'h04);
      peer_lsb <= 1'b1;
      xm(8'h0D, 8'hB0);
      wait_irq(1'b1);
      rdc(ST, 8'h8C);
      rdc(DA, 8'hB0);
      chk(peer_rx, 8'h0D);
      wr(ST, 8'h00);
      peer_lsb <= 1'b0;
      wr(CT, 8'h5F);
      xm(8'h81, 8'h7E);
      wait_irq(1'b1);
      rdc(ST, 8'h88);
      rdc(DA, 8'h7E);
      chk(peer_rx, 8'h81);
      wr(CT, 8'h52);
      $display("test order finished");
      xm(8'hFF, 8'h00);
      cyc(10);
      wr(CT, 8'h12);
      cyc(2);
      chk({7'h00, sck_oe_n_out}, 8'h01);
      cyc(80);
      rdc(ST, 8'h08);
      $display("test abort finished");
      for (int k = 0; k < 3; k++) begin
         wr(CT, f_ctl[k]);
         wr(ST, f_ie[k]);
         ss_n_in <= 1'b0;
         cyc(8);
         chk({7'h00, irq_fault_out}, f_irq[k]);
         rdc(CT, f_ce[k]);
         rdc(ST, f_st[k]);
         rdc(ST, f_st[k] & 8'hCF);
         ss_n_in <= 1'b1;
         cyc(4);
      end
      wr(CT, 8'h52);
      ss_n_in <= 1'b0;
      cyc(8);
      wr(CT, 8'h32);
      cyc(2);
      chk({7'h00, irq_fault_out}, 8'h00);
      rdc(ST, 8'h19);
      ss_n_in <= 1'b1;
      $display("test master fault finished");
      wr(ST, 8'h00);
      wr(CT, 8'h40);
      ss_n_in <= 1'b0;
      cyc(8);
      chk({7'h00, miso_oe_n_out}, 8'h00);
      pulses(4, 1'b0);
      ss_n_in <= 1'b1;
      cyc(8);
      chk({7'h00, miso_oe_n_out}, 8'h01);
      rdc(ST, 8'h18);
      ss_n_in <= 1'b0;
      cyc(8);
      pulses(8, 1'b1);
      wait_irq(1'b1);
      pulses(8, 1'b0);
      cyc(8);
      rdc(ST, 8'hA8);
      rdc(ST, 8'h88);
      rdc(DA, 8'hFF);
      rdc(ST, 8'h08);
      ss_n_in <= 1'b1;
      $display("test slave finished");
      tally_and_finish;
   end
endmodule
